//--- bench/bsf_chk.sv
// Concurrent checks on the ports of the bit, shift and flag block.
module bsf_chk (
  input  wire logic       clk_i,        // Core clock.
  input  wire logic       rstn_i,       // Synchronous reset, active low.
  input  wire logic       op_valid_i,   // Operation presented.
  input  bsf_pkg::bsf_op_t op_code_i,   // Operation code.
  input  wire logic [2:0] bit_idx_i,    // Bit index.
  input  wire logic [7:0] reg_data_i,   // Register operand.
  input  wire logic [4:0] io_addr_i,    // I/O address.
  input  wire logic [7:0] io_data_i,    // I/O register value.
  input  wire logic       reg_wr_o,     // Register write strobe.
  input  wire logic [7:0] reg_data_o,   // Register write data.
  input  wire logic       io_wr_o,      // I/O write strobe.
  input  wire logic [4:0] io_addr_o,    // I/O write address.
  input  wire logic [7:0] io_data_o,    // I/O write data.
  input  wire logic [7:0] flags_word_o, // Status word.
  input  wire logic       irq_en_o,     // Interrupt enable.
  input  wire logic       done_o        // Completion pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Shared clock and reset
  // ---------------------------------------------------------------------------
  // Reset disables every check, so nothing fires on values held during reset.
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_done;
    op_valid_i |=> done_o;
  endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_idle;
    op_valid_i && op_code_i == bsf_pkg::idle_op |=> !reg_wr_o && !io_wr_o
      && $stable(flags_word_o);
  endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");
  property p_ioset;
    op_valid_i && op_code_i == bsf_pkg::io_bit_set_op |=> io_wr_o && io_addr_o == $past(io_addr_i)
      && io_data_o == ($past(io_data_i) | (8'h01 << $past(bit_idx_i)));
  endproperty
  a_ioset: assert property (p_ioset) else $error("io set wrong");
  property p_ioclr;
    op_valid_i && op_code_i == bsf_pkg::io_bit_clear_op |=> io_wr_o
      && io_data_o == ($past(io_data_i) & ~(8'h01 << $past(bit_idx_i)));
  endproperty
  a_ioclr: assert property (p_ioclr) else $error("io clear wrong");
  property p_shl;
    op_valid_i && op_code_i == bsf_pkg::shift_left_op |=> reg_wr_o
      && reg_data_o == {$past(reg_data_i[6:0]), 1'b0};
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");
  property p_rol;
    op_valid_i && op_code_i == bsf_pkg::rotate_left_carry_op |=> reg_wr_o
      && flags_word_o[0] == $past(reg_data_i[7])
      && reg_data_o == {$past(reg_data_i[6:0]), $past(flags_word_o[0])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");
  property p_asr;
    op_valid_i && op_code_i == bsf_pkg::signed_shift_right_op |=> reg_wr_o
      && reg_data_o == {$past(reg_data_i[7]), $past(reg_data_i[7:1])};
  endproperty
  a_asr: assert property (p_asr) else $error("signed shift wrong");
  property p_swap;
    op_valid_i && op_code_i == bsf_pkg::nibble_swap_op |=> reg_data_o == {$past(reg_data_i[3:0]),
      $past(reg_data_i[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_fset;
    op_valid_i && op_code_i == bsf_pkg::flag_set_op |=> flags_word_o == ($past(flags_word_o)
      | (8'h01 << $past(bit_idx_i)));
  endproperty
  a_fset: assert property (p_fset) else $error("flag set wrong");
  property p_irq;
    op_valid_i && (op_code_i == bsf_pkg::irq_enable_op || op_code_i == bsf_pkg::irq_disable_op)
      |=> irq_en_o == ($past(op_code_i) == bsf_pkg::irq_enable_op)
      && flags_word_o[6:0] == $past(flags_word_o[6:0]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq enable wrong");
endmodule

bind bsf_top bsf_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .op_valid_i(op_valid_i),
  .op_code_i(op_code_i), .bit_idx_i(bit_idx_i), .reg_data_i(reg_data_i), .io_addr_i(io_addr_i),
  .io_data_i(io_data_i), .reg_wr_o(reg_wr_o), .reg_data_o(reg_data_o), .io_wr_o(io_wr_o),
  .io_addr_o(io_addr_o), .io_data_o(io_data_o), .flags_word_o(flags_word_o),
  .irq_en_o(irq_en_o), .done_o(done_o));

//--- bench/bsf_rf_model.sv
// Register file and I/O register model that feeds the block its operands.
module bsf_rf_model (
  input  wire logic       clk_i,   // Core clock.
  input  wire logic       ld_i,    // Bench preload strobe.
  input  wire logic [7:0] ld_rd_i, // Preload for the register.
  input  wire logic [7:0] ld_io_i, // Preload for the I/O register.
  input  wire logic       rwr_i,   // Register write strobe.
  input  wire logic [7:0] rdat_i,  // Register write data.
  input  wire logic       iwr_i,   // I/O write strobe.
  input  wire logic [7:0] idat_i,  // I/O write data.
  output logic [7:0]      rd_o,    // Register operand.
  output logic [7:0]      io_o     // I/O operand.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_r = 8'h00; // Stored register.
  logic [7:0] io_r = 8'h00; // Stored I/O register.
  // A write in flight is bypassed, so back to back operations see fresh data.
  assign rd_o = rwr_i ? rdat_i : rd_r;
  assign io_o = iwr_i ? idat_i : io_r;
  // Preload has priority over a write back.
  always @(posedge clk_i)
  begin
    if (ld_i)
    begin
      rd_r <= ld_rd_i;
      io_r <= ld_io_i;
    end
    else
    begin
      if (rwr_i)
        rd_r <= rdat_i;
      if (iwr_i)
        io_r <= idat_i;
    end
  end
endmodule

//--- bench/tb.sv
// Self-checking testbench for the bit, shift and flag block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i = 1'b0, rstn_i = 1'b0, op_valid_i = 1'b0, ld = 1'b0;
  bsf_pkg::bsf_op_t op_code_i = bsf_pkg::idle_op;
  logic [2:0]       bit_idx_i = 3'h0;
  logic [4:0]       io_addr_i = 5'h00, io_addr_o;
  logic [7:0]       ld_rd = 8'h00, ld_io = 8'h00, reg_data_i, io_data_i;
  logic [7:0]       reg_data_o, io_data_o, flags_word_o, ef;
  logic             reg_wr_o, io_wr_o, irq_en_o, done_o;
  logic [8:0]       v;
  int               n_mismatch = 0, check_count = 0;

  bsf_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .bit_idx_i(bit_idx_i), .reg_data_i(reg_data_i), .io_addr_i(io_addr_i), .io_data_i(io_data_i),
    .reg_wr_o(reg_wr_o), .reg_data_o(reg_data_o), .io_wr_o(io_wr_o), .io_addr_o(io_addr_o),
    .io_data_o(io_data_o), .flags_word_o(flags_word_o), .irq_en_o(irq_en_o), .done_o(done_o));
  bsf_rf_model u_rf (.clk_i(clk_i), .ld_i(ld), .ld_rd_i(ld_rd), .ld_io_i(ld_io), .rwr_i(reg_wr_o),
    .rdat_i(reg_data_o), .iwr_i(io_wr_o), .idat_i(io_data_o), .rd_o(reg_data_i), .io_o(io_data_i));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Optionally preloads operands in an idle cycle, then issues one operation.
  task automatic run_op(input bsf_pkg::bsf_op_t op, input logic [2:0] idx, input logic pre,
                        input logic [7:0] rd, input logic [7:0] iod);
    if (pre)
    begin
      op_valid_i = 1'b0;
      ld = 1'b1;
      ld_rd = rd;
      ld_io = iod;
      @(negedge clk_i);
      ld = 1'b0;
    end
    op_valid_i = 1'b1;
    op_code_i = op;
    bit_idx_i = idx;
    @(negedge clk_i);
    chk({7'h00, done_o}, 8'h01);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every bit position of a patterned I/O byte is set and cleared.
  task automatic t_io;
    for (int i = 0; i < 8; i++)
    begin
      io_addr_i = 5'(i + 3);
      run_op(bsf_pkg::io_bit_set_op, 3'(i), 1'b1, 8'h00, 8'h5a);
      chk(io_data_o, 8'h5a | (8'h01 << i));
      chk({2'h0, io_wr_o, io_addr_o}, 8'(i + 35));
      run_op(bsf_pkg::io_bit_clear_op, 3'(i), 1'b1, 8'h00, 8'h5a);
      chk(io_data_o, 8'h5a & ~(8'h01 << i));
    end
    $display("test io done");
  endtask
  // Each shift kind with the carry preset so a stray carry in would show.
  task automatic t_shift;
    bsf_pkg::bsf_op_t ops[6] = '{bsf_pkg::shift_left_op, bsf_pkg::shift_right_op,
      bsf_pkg::rotate_left_carry_op, bsf_pkg::rotate_right_carry_op,
      bsf_pkg::signed_shift_right_op, bsf_pkg::nibble_swap_op};
    logic [7:0] din[6] = '{8'h81, 8'h81, 8'h81, 8'h01, 8'h81, 8'h3c};
    logic [7:0] dex[6] = '{8'h02, 8'h40, 8'h02, 8'h80, 8'hc0, 8'hc3};
    logic       cin[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++)
    begin
      run_op(cin[i] ? bsf_pkg::carry_on_op : bsf_pkg::carry_off_op, 3'h0, 1'b1, din[i], 8'h00);
      run_op(ops[i], 3'h0, 1'b0, 8'h00, 8'h00);
      chk(reg_data_o, dex[i]);
      chk({7'h00, reg_wr_o}, 8'h01);
      if (i == 2 || i == 3)
        chk({7'h00, flags_word_o[0]}, 8'h01);
    end
    // Back to back rotates through carry form a nine bit ring.
    run_op(bsf_pkg::carry_off_op, 3'h0, 1'b1, 8'h81, 8'h00);
    v = 9'h081;
    for (int i = 0; i < 18; i++)
    begin
      run_op(i < 9 ? bsf_pkg::rotate_left_carry_op : bsf_pkg::rotate_right_carry_op, 3'h0, 1'b0,
             8'h00, 8'h00);
      v = (i < 9) ? {v[7:0], v[8]} : {v[0], v[8:1]};
      chk(reg_data_o, v[7:0]);
      chk({7'h00, flags_word_o[0]}, {7'h00, v[8]});
    end
    $display("test shift done");
  endtask
  // Indexed and dedicated flag operations against a tracked status word.
  task automatic t_flags;
    logic [2:0] fb[8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};
    for (int s = 0; s < 8; s++)
      run_op(bsf_pkg::flag_clear_op, 3'(s), 1'b0, 8'h00, 8'h00);
    ef = 8'h00;
    chk(flags_word_o, ef);
    for (int k = 0; k < 16; k++)
    begin
      run_op(k < 8 ? bsf_pkg::flag_set_op : bsf_pkg::flag_clear_op, 3'(k), 1'b0, 8'h00, 8'h00);
      ef[k % 8] = (k < 8);
      chk(flags_word_o, ef);
      chk({7'h00, irq_en_o}, {7'h00, ef[7]});
    end
    for (int i = 0; i < 16; i++)
    begin
      run_op(bsf_pkg::bsf_op_t'(bsf_pkg::carry_on_op + i), 3'h0, 1'b0, 8'h00, 8'h00);
      ef[fb[i / 2]] = ~i[0];
      chk(flags_word_o, ef);
      chk({7'h00, irq_en_o}, {7'h00, ef[7]});
    end
    $display("test flags done");
  endtask
  // Bit store and bit load in both polarities, then idle and no request.
  task automatic t_move;
    run_op(bsf_pkg::bit_to_transfer_op, 3'h5, 1'b1, 8'h20, 8'h00);
    chk(flags_word_o, 8'h40);
    run_op(bsf_pkg::transfer_to_bit_op, 3'h3, 1'b1, 8'h00, 8'h00);
    chk(reg_data_o, 8'h08);
    run_op(bsf_pkg::bit_to_transfer_op, 3'h5, 1'b1, 8'hdf, 8'h00);
    chk(flags_word_o, 8'h00);
    run_op(bsf_pkg::transfer_to_bit_op, 3'h3, 1'b1, 8'hff, 8'h00);
    chk(reg_data_o, 8'hf7);
    run_op(bsf_pkg::signed_on_op, 3'h0, 1'b0, 8'h00, 8'h00);
    run_op(bsf_pkg::idle_op, 3'h7, 1'b0, 8'h00, 8'h00);
    chk(flags_word_o, 8'h10);
    chk({6'h00, reg_wr_o, io_wr_o}, 8'h00);
    op_valid_i = 1'b0;
    @(negedge clk_i);
    chk({6'h00, done_o, reg_wr_o}, 8'h00);
    $display("test move done");
  endtask

  initial
  begin
    repeat (16) @(negedge clk_i);
    chk(flags_word_o, bsf_pkg::FLAGS_RST);
    chk({4'h0, reg_wr_o, io_wr_o, irq_en_o, done_o}, 8'h00);
    rstn_i = 1'b1;
    $display("test reset done");
    t_io;
    t_shift;
    t_flags;
    t_move;
    give_verdict;
  end
endmodule

//--- src/bsf_dp_if.sv
// Interface joining the top level to its shift and flag units.
interface bsf_dp_if;

  bsf_pkg::bsf_op_t op;        // Operation being executed.
  logic [7:0]       operand;   // Register operand.
  logic [2:0]       idx;       // Bit index b or s.
  logic [7:0]       flags;     // Current status word.
  logic [7:0]       sh_data;   // Shift unit result.
  logic             sh_carry;  // Shift unit carry out.
  logic             sh_wr_c;   // Shift unit updates the carry.
  logic [7:0]       fl_next;   // Flag unit next status word.

  // Top drives the operation and reads both results.
  modport top (output op, output operand, output idx, output flags,
               input sh_data, input sh_carry, input sh_wr_c, input fl_next);

  // Shift unit reads the operation and returns data and carry.
  modport shift (input op, input operand, input flags,
                 output sh_data, output sh_carry, output sh_wr_c);

  // Flag unit reads the operation and returns the next status word.
  modport flag (input op, input operand, input idx, input flags,
                output fl_next);

endinterface

//--- src/bsf_flag_unit.sv
// Combinational next-state logic for the status word.
module bsf_flag_unit (
  bsf_dp_if.flag dp
);

  // ---------------------------------------------------------------------------
  // Next status word
  // ---------------------------------------------------------------------------
  // Each operation touches one bit through the helper, so the others are kept.
  always_comb
  begin
    dp.fl_next = dp.flags;
    case (dp.op)
      bsf_pkg::flag_set_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, dp.idx, 1'b1);  // RL9
      bsf_pkg::flag_clear_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, dp.idx, 1'b0);  // RL9
      bsf_pkg::bit_to_transfer_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_T, dp.operand[dp.idx]);  // RL10
      bsf_pkg::carry_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_C, 1'b1);  // RL12
      bsf_pkg::carry_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_C, 1'b0);  // RL12
      bsf_pkg::irq_enable_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_I, 1'b1);  // RL13
      bsf_pkg::irq_disable_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_I, 1'b0);  // RL13
      bsf_pkg::signed_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_S, 1'b1);  // RL14
      bsf_pkg::signed_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_S, 1'b0);  // RL14
      bsf_pkg::transfer_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_T, 1'b1);  // RL15
      bsf_pkg::transfer_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_T, 1'b0);  // RL15
      bsf_pkg::half_carry_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_H, 1'b1);  // RL15
      bsf_pkg::half_carry_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_H, 1'b0);  // RL15
      bsf_pkg::negative_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_N, 1'b1);  // RL16
      bsf_pkg::negative_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_N, 1'b0);  // RL16
      bsf_pkg::zero_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_Z, 1'b1);  // RL16
      bsf_pkg::zero_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_Z, 1'b0);  // RL16
      bsf_pkg::overflow_on_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_V, 1'b1);  // RL16
      bsf_pkg::overflow_off_op:
        dp.fl_next = bsf_pkg::bsf_put_bit(dp.flags, bsf_pkg::FLAG_V, 1'b0);  // RL16
      default:                        dp.fl_next = dp.flags;  // RL18
    endcase
  end

endmodule

//--- src/bsf_pkg.sv
// Package with opcodes, flag positions, reset values and shared bit helpers.
package bsf_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;  // Width of every data operand.
  localparam int unsigned IDX_W  = 3;  // Width of a bit index inside a byte.
  localparam int unsigned IOA_W  = 5;  // Width of a bit-addressable I/O address.

  // ---------------------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;  // Carry.
  localparam logic [2:0] FLAG_Z = 3'h1;  // Zero.
  localparam logic [2:0] FLAG_N = 3'h2;  // Negative.
  localparam logic [2:0] FLAG_V = 3'h3;  // Two's complement overflow.
  localparam logic [2:0] FLAG_S = 3'h4;  // Signed test.
  localparam logic [2:0] FLAG_H = 3'h5;  // Half carry.
  localparam logic [2:0] FLAG_T = 3'h6;  // Transfer bit.
  localparam logic [2:0] FLAG_I = 3'h7;  // Global interrupt enable.

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h00;  // Status word after reset.
  localparam logic [7:0] DATA_RST  = 8'h00;  // Data outputs after reset.
  localparam logic [4:0] IOA_RST   = 5'h00;  // I/O address output after reset.

  // ---------------------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    idle_op,
    io_bit_set_op,
    io_bit_clear_op,
    shift_left_op,
    shift_right_op,
    rotate_left_carry_op,
    rotate_right_carry_op,
    signed_shift_right_op,
    nibble_swap_op,
    flag_set_op,
    flag_clear_op,
    bit_to_transfer_op,
    transfer_to_bit_op,
    carry_on_op,
    carry_off_op,
    negative_on_op,
    negative_off_op,
    zero_on_op,
    zero_off_op,
    irq_enable_op,
    irq_disable_op,
    signed_on_op,
    signed_off_op,
    overflow_on_op,
    overflow_off_op,
    transfer_on_op,
    transfer_off_op,
    half_carry_on_op,
    half_carry_off_op
  } bsf_op_t;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Returns the byte with one bit forced to a value and all others kept.
  function automatic logic [7:0] bsf_put_bit(input logic [7:0] data,
                                             input logic [2:0] idx,
                                             input logic       val);
    logic [7:0] res;
    res      = data;
    res[idx] = val;
    return res;
  endfunction

endpackage

//--- src/bsf_shift_unit.sv
// Combinational shift, rotate and nibble swap unit.
module bsf_shift_unit (
  bsf_dp_if.shift dp
);

  // ---------------------------------------------------------------------------
  // Result selection
  // ---------------------------------------------------------------------------
  // Every path assigns all three outputs so no latch can form.
  always_comb
  begin
    dp.sh_data  = dp.operand;
    dp.sh_carry = dp.flags[bsf_pkg::FLAG_C];
    dp.sh_wr_c  = 1'b0;
    case (dp.op)
      bsf_pkg::shift_left_op:
      begin
        dp.sh_data = {dp.operand[6:0], 1'b0};  // RL3
      end
      bsf_pkg::shift_right_op:
      begin
        dp.sh_data = {1'b0, dp.operand[7:1]};  // RL4
      end
      bsf_pkg::rotate_left_carry_op:
      begin
        dp.sh_data  = {dp.operand[6:0], dp.flags[bsf_pkg::FLAG_C]};  // RL5
        dp.sh_carry = dp.operand[7];  // RL5
        dp.sh_wr_c  = 1'b1;
      end
      bsf_pkg::rotate_right_carry_op:
      begin
        dp.sh_data  = {dp.flags[bsf_pkg::FLAG_C], dp.operand[7:1]};  // RL6
        dp.sh_carry = dp.operand[0];  // RL6
        dp.sh_wr_c  = 1'b1;
      end
      bsf_pkg::signed_shift_right_op:
      begin
        // The sign bit stays put so negative values stay negative.
        dp.sh_data = {dp.operand[7], dp.operand[7:1]};  // RL7
      end
      bsf_pkg::nibble_swap_op:
      begin
        dp.sh_data = {dp.operand[3:0], dp.operand[7:4]};  // RL8
      end
      default:
      begin
        dp.sh_data = dp.operand;
      end
    endcase
  end

endmodule

//--- src/bsf_top.sv
// Top level of the bit, shift and flag execution block.

// Function
// RL1 - I/O bit set forces bit b high
// RL2 - I/O bit clear forces bit b low
// RL3 - Left shift moves bits up, zero in
// RL4 - Right shift moves bits down, zero in
// RL5 - Rotate left: carry in, bit 7 out
// RL6 - Rotate right: carry in, bit 0 out
// RL7 - Signed right shift keeps bit 7
// RL8 - Swap exchanges upper and lower nibble
// RL9 - Indexed flag set or clear by s
// RL10 - Bit store copies source bit to T
// RL11 - Bit load copies T into bit b
// RL12 - Carry forced on or off
// RL13 - Interrupt enable flag set or cleared
// RL14 - Signed test flag set or cleared
// RL15 - Transfer and half carry set or cleared
// RL16 - Negative, zero, overflow set or cleared
// RL17 - Idle operation changes nothing
// RL18 - Flag operations keep other status bits
module bsf_top (
  input  wire logic             clk_i,       // Core clock, 100 MHz.
  input  wire logic             rstn_i,      // Synchronous reset, active low.
  input  wire logic             op_valid_i,  // Operation is presented this cycle.
  input  bsf_pkg::bsf_op_t      op_code_i,   // Operation to execute.
  input  wire logic [2:0]       bit_idx_i,   // Bit index b or s.
  input  wire logic [7:0]       reg_data_i,  // Register operand Rd or Rr.
  input  wire logic [4:0]       io_addr_i,   // I/O address P.
  input  wire logic [7:0]       io_data_i,   // Current I/O register value.
  output logic                  reg_wr_o,    // Register write strobe.
  output logic [7:0]            reg_data_o,  // Register write data.
  output logic                  io_wr_o,     // I/O register write strobe.
  output logic [4:0]            io_addr_o,   // I/O register write address.
  output logic [7:0]            io_data_o,   // I/O register write data.
  output logic [7:0]            flags_word_o, // Status word.
  output logic                  irq_en_o,    // Interrupt acceptance enable.
  output logic                  done_o       // Operation finished pulse.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // All state in one record so reset and update stay in one place.
  typedef struct packed {
    logic       reg_wr;    // Register write strobe.
    logic [7:0] reg_data;  // Register write data.
    logic       io_wr;     // I/O write strobe.
    logic [4:0] io_addr;   // I/O write address.
    logic [7:0] io_data;   // I/O write data.
    logic [7:0] flags;     // Status word.
    logic       done;      // Completion pulse.
  } bsf_state_t;

  bsf_state_t st_r;    // Registered state.
  bsf_state_t st_nxt;  // Next state.

  // ---------------------------------------------------------------------------
  // Datapath units
  // ---------------------------------------------------------------------------
  bsf_dp_if dp ();  // Carrier between this level and the two units.

  // An idle code is presented to the units when no operation is valid, so
  // their results equal the inputs and nothing can leak through.
  assign dp.op      = op_valid_i ? op_code_i : bsf_pkg::idle_op;
  assign dp.operand = reg_data_i;
  assign dp.idx     = bit_idx_i;
  assign dp.flags   = st_r.flags;

  bsf_shift_unit u_shift (
    .dp (dp.shift)
  );

  bsf_flag_unit u_flag (
    .dp (dp.flag)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Strobes drop every cycle unless an operation raises them, so they are
  // one-cycle pulses. Flags start from the flag unit, which keeps them
  // when the operation is not a flag operation.
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.reg_wr   = 1'b0;
    st_nxt.io_wr    = 1'b0;
    st_nxt.done     = 1'b0;
    st_nxt.flags    = dp.fl_next;
    if (op_valid_i)
    begin
      st_nxt.done = 1'b1;
      case (op_code_i)
        bsf_pkg::io_bit_set_op:
        begin
          // Read-modify-write of the addressed I/O register.
          st_nxt.io_wr   = 1'b1;
          st_nxt.io_addr = io_addr_i;
          st_nxt.io_data = bsf_pkg::bsf_put_bit(io_data_i, bit_idx_i, 1'b1);  // RL1
        end
        bsf_pkg::io_bit_clear_op:
        begin
          st_nxt.io_wr   = 1'b1;
          st_nxt.io_addr = io_addr_i;
          st_nxt.io_data = bsf_pkg::bsf_put_bit(io_data_i, bit_idx_i, 1'b0);  // RL2
        end
        bsf_pkg::shift_left_op,
        bsf_pkg::shift_right_op,
        bsf_pkg::rotate_left_carry_op,
        bsf_pkg::rotate_right_carry_op,
        bsf_pkg::signed_shift_right_op,
        bsf_pkg::nibble_swap_op:
        begin
          st_nxt.reg_wr   = 1'b1;
          st_nxt.reg_data = dp.sh_data;
          // Only the rotates move a bit into carry here.
          if (dp.sh_wr_c)
          begin
            st_nxt.flags[bsf_pkg::FLAG_C] = dp.sh_carry;  // RL5 RL6
          end
        end
        bsf_pkg::transfer_to_bit_op:
        begin
          st_nxt.reg_wr   = 1'b1;
          st_nxt.reg_data = bsf_pkg::bsf_put_bit(reg_data_i, bit_idx_i,
                                                 st_r.flags[bsf_pkg::FLAG_T]);  // RL11
        end
        bsf_pkg::idle_op:
        begin
          // No write and no flag change, just completion.
          st_nxt.flags = st_r.flags;  // RL17
        end
        default:
        begin
          // Flag operations: the flag unit result already stands.
          st_nxt.reg_wr = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset is synchronous, so it takes effect only on a clock edge.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st_r.reg_wr   <= 1'b0;
      st_r.reg_data <= bsf_pkg::DATA_RST;
      st_r.io_wr    <= 1'b0;
      st_r.io_addr  <= bsf_pkg::IOA_RST;
      st_r.io_data  <= bsf_pkg::DATA_RST;
      st_r.flags    <= bsf_pkg::FLAGS_RST;
      st_r.done     <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Every output is a plain copy of a state flop.
  assign reg_wr_o     = st_r.reg_wr;
  assign reg_data_o   = st_r.reg_data;
  assign io_wr_o      = st_r.io_wr;
  assign io_addr_o    = st_r.io_addr;
  assign io_data_o    = st_r.io_data;
  assign flags_word_o = st_r.flags;
  assign irq_en_o     = st_r.flags[bsf_pkg::FLAG_I];  // RL13
  assign done_o       = st_r.done;

endmodule
